// File: rtcirq_ctrl.sv
// Interrupt-pending flag, periodic output and chip-select gating.
// Assumes bus pins and carry ticks arrive asynchronously from outside;
// every such input is synchronised before use.
`timescale 1ns/1ps
`include "rtcirq_consts.svh"

// Summary of operation
// RULE1 - Control registers are read and written regardless of hold or busy.
// RULE2 - Writing 0 to the flag clears it and releases the periodic output.
// RULE3 - Any status write with 0 in the flag position clears the flag.
// RULE4 - Writing 1 to the flag position neither sets nor clears it.
// RULE5 - The host writes 1 to the flag position unless it means to clear.
// RULE6 - Rewriting period or pulse-mode bits may raise the flag.
// RULE7 - After such a change the host clears the flag to drop stale events.
// RULE8 - While first chip select is low, the bus is ignored and undriven.
// RULE9 - First chip select blocks the bus across standby entry and exit.
// RULE10 - With mask 0, a selected carry sets the flag and drives the pin low.
// RULE11 - Set flag ignores events until cleared, or 7.8125 ms in waveform.
// RULE12 - First chip select going low forces the hold bit to 0.
// RULE13 - A clear meeting a new event in one cycle loses to the event.
module rtcirq_ctrl (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Host bus pins
  input wire logic first_chip_select_in,
  input wire logic wr_n_in,
  input wire logic rd_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [3:0] data_in,
  output logic [3:0] data_out,
  output logic data_oe_out,
  // Carry ticks into the clock digits: 1/64 s, s, min, hour
  input wire logic [3:0] carry_in,
  // Status seen by the timekeeping core
  input wire logic busy_in,
  output logic hold_out,
  output logic half_minute_adjust_out,
  output logic [3:0] clock_control_out,
  // Periodic output pin, open drain
  output logic periodic_output_pin_out,
  output logic periodic_output_pin_oe_out
);
  logic rst_m_q;
  logic rst_q;
  logic rst_n;
  logic cs_s;
  logic wr_s;
  logic rd_s;
  logic [3:0] carry_s;
  logic [3:0] addr_s [0:1];
  logic [3:0] data_s [0:1];
  logic [3:0] addr_l;
  logic [3:0] data_l;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_m_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_q <= rst_m_q;
    end
  end
  assign rst_n = rst_q;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  rtcirq_sync u_cs (.clk_in(clk_in), .arst_n_in(rst_n),
    .d_in(first_chip_select_in), .q_out(cs_s));
  rtcirq_sync u_wr (.clk_in(clk_in), .arst_n_in(rst_n),
    .d_in(~wr_n_in), .q_out(wr_s));
  rtcirq_sync u_rd (.clk_in(clk_in), .arst_n_in(rst_n),
    .d_in(~rd_n_in), .q_out(rd_s));

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      rtcirq_sync u_cy (.clk_in(clk_in), .arst_n_in(rst_n),
        .d_in(carry_in[gi]), .q_out(carry_s[gi]));
    end
  endgenerate

  // Address and data are sampled as a bundle; they are stable while
  // the strobe is synchronised, so a two-deep array suffices.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      addr_s[0] <= 4'h0;
      addr_s[1] <= 4'h0;
      data_s[0] <= 4'h0;
      data_s[1] <= 4'h0;
    end else begin
      addr_s[0] <= addr_in;
      addr_s[1] <= addr_s[0];
      data_s[0] <= data_in;
      data_s[1] <= data_s[0];
    end
  end
  assign addr_l = addr_s[1];
  assign data_l = data_s[1];

  // ---------------------------------------------------------------
  // Write strobe edge gated by chip select; deselect and carry edges
  // ---------------------------------------------------------------
  logic wr_act_q;
  logic wr_act_d;
  logic cs_q;
  logic cs_d;
  logic wr_pulse;
  logic cs_fall;
  logic [3:0] carry_q;
  logic [3:0] carry_d;
  logic [3:0] carry_rise;

  always_comb begin
    wr_act_d = wr_s & cs_s; // [RULE8] [RULE9]
    cs_d = cs_s;
    carry_d = carry_s;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_act_q <= 1'b0;
      cs_q <= 1'b0;
      carry_q <= 4'h0;
    end else begin
      wr_act_q <= wr_act_d;
      cs_q <= cs_d;
      carry_q <= carry_d;
    end
  end

  assign wr_pulse = wr_act_d & ~wr_act_q;
  assign cs_fall = cs_q & ~cs_s;
  assign carry_rise = carry_s & ~carry_q;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic hold_q;
  logic hold_d;
  logic adj_q;
  logic adj_d;
  logic [3:0] ce_q;
  logic [3:0] ce_d;
  logic [3:0] cf_q;
  logic [3:0] cf_d;
  logic wr_sr;
  logic wr_ce;
  logic clr_req;
  logic mode_chg;

  always_comb begin
    wr_sr = wr_pulse && addr_l == `RTCIRQ_ADDR_STATUS;
    wr_ce = wr_pulse && addr_l == `RTCIRQ_ADDR_CTRL_E;
    hold_d = hold_q;
    adj_d = 1'b0;
    ce_d = ce_q;
    cf_d = cf_q;
    // No hold or busy term gates these writes.
    if (wr_sr) begin // [RULE1]
      hold_d = data_l[`RTCIRQ_SR_HOLD];
      adj_d = data_l[`RTCIRQ_SR_ADJ];
    end
    if (wr_ce) begin // [RULE1]
      ce_d = data_l;
    end
    if (wr_pulse && addr_l == `RTCIRQ_ADDR_CTRL_F) begin // [RULE1]
      cf_d = data_l;
    end
    if (cs_fall) begin
      hold_d = 1'b0; // [RULE12]
    end
    clr_req = wr_sr && !data_l[`RTCIRQ_SR_IRQ]; // [RULE2] [RULE3] [RULE4]
    // Rewriting period or mode bits restarts the phase; treat it as an
    // event, so the host must clear afterwards.
    mode_chg = wr_ce && (data_l[3:1] != ce_q[3:1]); // [RULE6]
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
      adj_q <= 1'b0;
      ce_q <= `RTCIRQ_CE_RESET;
      cf_q <= `RTCIRQ_CF_RESET;
    end else begin
      hold_q <= hold_d;
      adj_q <= adj_d;
      ce_q <= ce_d;
      cf_q <= cf_d;
    end
  end

  // ---------------------------------------------------------------
  // Flag state machine
  // ---------------------------------------------------------------
  rtcirq_pkg::rtcirq_state_t st_q;
  rtcirq_pkg::rtcirq_state_t st_d;
  logic [`RTCIRQ_CNT_W-1:0] cnt_q;
  logic [`RTCIRQ_CNT_W-1:0] cnt_d;
  logic event_hit;

  always_comb begin
    event_hit = !ce_q[`RTCIRQ_CE_MASK] &&
      (carry_rise[ce_q[3:2]] || mode_chg); // [RULE10] [RULE6]
    st_d = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      rtcirq_pkg::RTCIRQ_ST_IDLE: begin
        if (event_hit) begin // [RULE13]
          st_d = ce_q[`RTCIRQ_CE_PMODE] ? rtcirq_pkg::RTCIRQ_ST_PEND
                                        : rtcirq_pkg::RTCIRQ_ST_PULSE;
          cnt_d = `RTCIRQ_CNT_W'(`RTCIRQ_PULSE_CYC - 1);
        end
      end
      rtcirq_pkg::RTCIRQ_ST_PEND: begin
        // New events are dropped while pending.
        if (clr_req && !event_hit) begin // [RULE11] [RULE2] [RULE13]
          st_d = rtcirq_pkg::RTCIRQ_ST_IDLE;
        end
      end
      rtcirq_pkg::RTCIRQ_ST_PULSE: begin
        cnt_d = cnt_q - `RTCIRQ_CNT_W'(1);
        if ((clr_req && !event_hit) || cnt_q == '0) begin // [RULE11]
          st_d = rtcirq_pkg::RTCIRQ_ST_IDLE;
        end
      end
      default: st_d = rtcirq_pkg::RTCIRQ_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= rtcirq_pkg::RTCIRQ_ST_IDLE;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  logic flag;
  assign flag = st_q != rtcirq_pkg::RTCIRQ_ST_IDLE;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [3:0] rd_q;
  logic [3:0] rd_d;
  logic oe_q;
  logic oe_d;

  always_comb begin
    oe_d = rd_s & cs_s; // [RULE8]
    unique case (addr_l)
      `RTCIRQ_ADDR_STATUS: rd_d = {adj_q, flag, busy_in, hold_q};
      `RTCIRQ_ADDR_CTRL_E: rd_d = ce_q;
      `RTCIRQ_ADDR_CTRL_F: rd_d = cf_q;
      default: rd_d = 4'h0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 4'h0;
      oe_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      oe_q <= oe_d;
    end
  end

  assign data_out = rd_q;
  assign data_oe_out = oe_q;
  assign hold_out = hold_q;
  assign half_minute_adjust_out = adj_q;
  assign clock_control_out = cf_q;
  assign periodic_output_pin_out = 1'b0;
  assign periodic_output_pin_oe_out = flag; // [RULE10]

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  bus_block_a: assert property (!cs_s |=> !oe_q) // [RULE8]
    else $error("Data driven while chip select low.");
  clear_flag_a: assert property ( // [RULE2]
    st_q == rtcirq_pkg::RTCIRQ_ST_PEND && clr_req && !event_hit
    |=> !flag)
    else $error("Flag not cleared by zero write.");
  one_keeps_a: assert property ( // [RULE4]
    wr_sr && data_l[`RTCIRQ_SR_IRQ] && flag
    && st_q == rtcirq_pkg::RTCIRQ_ST_PEND |=> flag)
    else $error("Writing one changed the flag.");
  any_clear_a: assert property ( // [RULE3]
    wr_sr && !data_l[`RTCIRQ_SR_IRQ] && !event_hit |=> !flag)
    else $error("Status write with zero left flag set.");
  event_set_a: assert property ( // [RULE10]
    !flag && event_hit |=> flag)
    else $error("Carry did not raise the flag.");
  pend_holds_a: assert property ( // [RULE11]
    st_q == rtcirq_pkg::RTCIRQ_ST_PEND && !clr_req |=> flag)
    else $error("Interrupt flag dropped without clear.");
  pulse_end_a: assert property ( // [RULE11]
    st_q == rtcirq_pkg::RTCIRQ_ST_PULSE && cnt_q == '0 |=> !flag)
    else $error("Waveform pulse outlived its width.");
  pin_match_a: assert property ( // [RULE10]
    periodic_output_pin_oe_out == flag)
    else $error("Output pin disagrees with flag.");
  hold_drop_a: assert property (cs_fall |=> !hold_q) // [RULE12]
    else $error("Hold not forced low on deselect.");
  race_win_a: assert property ( // [RULE13]
    !flag && event_hit && clr_req |=> flag)
    else $error("Clear beat a simultaneous event.");
  ce_write_a: assert property ( // [RULE1]
    wr_ce |=> ce_q == $past(data_l))
    else $error("Control write lost.");
  mask_quiet_a: assert property ( // [RULE6]
    !flag && ce_q[`RTCIRQ_CE_MASK] |=> !flag)
    else $error("Flag set while masked.");

  pulse_c: cover property (st_q == rtcirq_pkg::RTCIRQ_ST_PULSE
    ##1 st_q == rtcirq_pkg::RTCIRQ_ST_IDLE);
  pend_c: cover property (st_q == rtcirq_pkg::RTCIRQ_ST_PEND && clr_req);
  deselect_c: cover property (cs_fall && hold_q);
endmodule : rtcirq_ctrl

// File: rtcirq_consts.svh
// Constants for the interrupt flag and chip-select control block.
// Assumes a 100 MHz system clock and a 4-bit host bus.
`ifndef RTCIRQ_CONSTS_SVH
`define RTCIRQ_CONSTS_SVH

// ---------------------------------------------------------------
// Register addresses on the 4-bit bus
// ---------------------------------------------------------------
`define RTCIRQ_ADDR_STATUS 4'hD
`define RTCIRQ_ADDR_CTRL_E 4'hE
`define RTCIRQ_ADDR_CTRL_F 4'hF

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RTCIRQ_SR_HOLD 0
`define RTCIRQ_SR_BUSY 1
`define RTCIRQ_SR_IRQ 2
`define RTCIRQ_SR_ADJ 3
`define RTCIRQ_CE_MASK 0
`define RTCIRQ_CE_PMODE 1
`define RTCIRQ_CE_PLOW 2
`define RTCIRQ_CE_PHIGH 3

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RTCIRQ_SR_RESET 4'h0
`define RTCIRQ_CE_RESET 4'h1
`define RTCIRQ_CF_RESET 4'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RTCIRQ_CLK_HZ 100000000
`define RTCIRQ_PULSE_NS 7812500
`define RTCIRQ_PULSE_CYC ((`RTCIRQ_PULSE_NS / 10))
`define RTCIRQ_CNT_W 20

`endif

// File: rtcirq_pkg.sv
// Types for the interrupt flag and chip-select control block.
// Assumes the constants header is compiled alongside.
package rtcirq_pkg;
  typedef enum logic [1:0] {
    RTCIRQ_SEL_64TH = 2'b00,
    RTCIRQ_SEL_SEC = 2'b01,
    RTCIRQ_SEL_MIN = 2'b10,
    RTCIRQ_SEL_HOUR = 2'b11
  } rtcirq_period_t;

  typedef enum logic [2:0] {
    RTCIRQ_ST_IDLE = 3'b001,
    RTCIRQ_ST_PEND = 3'b010,
    RTCIRQ_ST_PULSE = 3'b100
  } rtcirq_state_t;
endpackage : rtcirq_pkg

// File: rtcirq_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the destination clock is clk_in.
`timescale 1ns/1ps
module rtcirq_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Level
  input wire logic d_in,
  output logic q_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = d_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_out = sync_q;
endmodule : rtcirq_sync

// File: rtcirq_host.sv
// Host microcomputer model driving the 4-bit bus of the flag block.
// Assumes the device samples every bus pin through two flip-flops.
`timescale 1ns/1ps
`include "rtcirq_consts.svh"
module rtcirq_host (
  // Clock
  input wire logic clk_in,
  // Bus towards the device
  output logic cs_out,
  output logic wr_n_out,
  output logic rd_n_out,
  output logic [3:0] addr_out,
  output logic [3:0] data_out,
  // Answer from the device
  input wire logic [3:0] rdata_in,
  input wire logic rdata_oe_in
);
  initial begin
    cs_out = 1'b1;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    addr_out = 4'h0;
    data_out = 4'h0;
  end

  // Strobes stay six cycles and the data four more, which covers
  // the two-flop sampling on the far side with margin.
  task automatic write_reg(input logic [3:0] addr, input logic [3:0] data);
    @(posedge clk_in);
    addr_out <= addr;
    data_out <= data;
    @(posedge clk_in);
    wr_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    wr_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    // A released data bus does not keep its last value.
    data_out <= ~data;
    repeat (3) @(posedge clk_in);
  endtask : write_reg

  // The flag position carries 1 unless the caller means to clear it.
  task automatic write_status(input logic hold, input logic adj,
                              input logic clear);
    write_reg(`RTCIRQ_ADDR_STATUS, {adj, ~clear, 1'b0, hold});
  endtask : write_status

  task automatic read_reg(input logic [3:0] addr, output logic [3:0] data,
                          output logic oe);
    @(posedge clk_in);
    addr_out <= addr;
    @(posedge clk_in);
    rd_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    data = rdata_in;
    oe = rdata_oe_in;
    rd_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask : read_reg

  task automatic select(input logic on);
    @(posedge clk_in);
    cs_out <= on;
    repeat (6) @(posedge clk_in);
  endtask : select
endmodule : rtcirq_host

// File: tb.sv
// Self-checking testbench for the flag and chip-select block.
// Assumes the host model drives the bus and the bench drives carries.
`timescale 1ns/1ps
`include "rtcirq_consts.svh"
module tb;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cs, wr_n, rd_n, rdata_oe, hold, adj, pin, pin_oe;
  logic [3:0] addr, wdata, rdata, cf;
  logic [3:0] carry = 4'h0;
  logic busy = 1'b0;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int adj_pulses = 0;

  always #5 clk_in = ~clk_in;

  rtcirq_host host (.clk_in(clk_in), .cs_out(cs), .wr_n_out(wr_n),
    .rd_n_out(rd_n), .addr_out(addr), .data_out(wdata),
    .rdata_in(rdata), .rdata_oe_in(rdata_oe));

  rtcirq_ctrl dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .first_chip_select_in(cs), .wr_n_in(wr_n), .rd_n_in(rd_n),
    .addr_in(addr), .data_in(wdata), .data_out(rdata),
    .data_oe_out(rdata_oe), .carry_in(carry), .busy_in(busy),
    .hold_out(hold), .half_minute_adjust_out(adj),
    .clock_control_out(cf), .periodic_output_pin_out(pin),
    .periodic_output_pin_oe_out(pin_oe));

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Read data is only compared when the caller expects the device to claim the bus.
  task automatic rd(input logic [3:0] a, input logic [3:0] exp,
                    input logic exp_oe);
    logic [3:0] d;
    logic oe;
    host.read_reg(a, d, oe);
    check(4'(oe), 4'(exp_oe));
    if (exp_oe === 1'b1) begin
      check(d, exp);
    end
  endtask : rd

  // Carries are levels; the rising edge is the event.
  task automatic tick(input int i);
    @(posedge clk_in);
    carry[i] <= 1'b1;
    repeat (8) @(posedge clk_in);
    carry[i] <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask : tick

  // The run needs about 700 cycles; twenty thousand is a hang.
  always @(posedge clk_in) begin
    cycles++;
    if (adj === 1'b1) begin
      adj_pulses++;
    end
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Select a period in interrupt mode from an unmasked setting, drop the
  // side-effect flag, then show that only the selected carry counts.
  task automatic period(input logic [3:0] ce, input int quiet,
                        input int live);
    host.write_reg(`RTCIRQ_ADDR_CTRL_E, ce);
    check(4'(pin_oe), 4'h1);
    host.write_status(1'b0, 1'b0, 1'b1);
    check(4'(pin_oe), 4'h0);
    tick(quiet);
    check(4'(pin_oe), 4'h0);
    tick(live);
    check(4'(pin_oe), 4'h1);
    host.write_status(1'b0, 1'b0, 1'b1);
    check(4'(pin_oe), 4'h0);
  endtask : period

  initial begin
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd(`RTCIRQ_ADDR_CTRL_E, `RTCIRQ_CE_RESET, 1'b1);
    rd(`RTCIRQ_ADDR_CTRL_F, `RTCIRQ_CF_RESET, 1'b1);
    rd(4'h3, 4'h0, 1'b1);
    // Masked after reset: the selected carry must stay silent.
    tick(0);
    check(4'(pin_oe), 4'h0);
    // Control access must not depend on hold or busy.
    busy <= 1'b1;
    host.write_status(1'b1, 1'b0, 1'b0);
    check(4'(hold), 4'h1);
    rd(`RTCIRQ_ADDR_STATUS, 4'h3, 1'b1);
    host.write_reg(`RTCIRQ_ADDR_CTRL_F, 4'hA);
    check(cf, 4'hA);
    rd(`RTCIRQ_ADDR_CTRL_F, 4'hA, 1'b1);
    // Unmask, interrupt mode, one-second period. The mask still stands
    // while the mode bits change, so no side-effect flag is raised.
    host.write_reg(`RTCIRQ_ADDR_CTRL_E, 4'h6);
    check(4'(pin_oe), 4'h0);
    rd(`RTCIRQ_ADDR_STATUS, 4'h3, 1'b1);
    host.write_status(1'b1, 1'b0, 1'b1);
    check(4'(pin_oe), 4'h0);
    check(4'(hold), 4'h1);
    host.write_status(1'b1, 1'b0, 1'b0);
    check(4'(pin_oe), 4'h0);
    tick(0);
    check(4'(pin_oe), 4'h0);
    tick(1);
    check(4'(pin_oe), 4'h1);
    check(4'(pin), 4'h0);
    host.write_status(1'b1, 1'b0, 1'b0);
    check(4'(pin_oe), 4'h1);
    tick(1);
    rd(`RTCIRQ_ADDR_STATUS, 4'h7, 1'b1);
    host.write_status(1'b0, 1'b1, 1'b0);
    check(4'(adj_pulses), 4'h1);
    check(4'(pin_oe), 4'h1);
    // Zero in the flag position clears even when adjust is the target.
    host.write_status(1'b0, 1'b1, 1'b1);
    check(4'(adj_pulses), 4'h2);
    check(4'(pin_oe), 4'h0);
    // The carry edge and the clearing strobe leave their synchronisers
    // in the same cycle; the event must win.
    fork
      host.write_status(1'b0, 1'b0, 1'b1);
      begin
        @(posedge clk_in);
        tick(1);
      end
    join
    check(4'(pin_oe), 4'h1);
    host.write_status(1'b0, 1'b0, 1'b1);
    check(4'(pin_oe), 4'h0);
    // Minute, hour and 1/64 s periods.
    period(4'hA, 3, 2);
    period(4'hE, 2, 3);
    period(4'h2, 1, 0);
    // Waveform mode: the pulse also ends on a written clear.
    host.write_reg(`RTCIRQ_ADDR_CTRL_E, 4'h4);
    check(4'(pin_oe), 4'h1);
    host.write_status(1'b0, 1'b0, 1'b1);
    check(4'(pin_oe), 4'h0);
    tick(1);
    check(4'(pin_oe), 4'h1);
    host.write_status(1'b0, 1'b0, 1'b1);
    check(4'(pin_oe), 4'h0);
    // Deselect: hold drops, bus is dead, state survives.
    host.write_status(1'b1, 1'b0, 1'b0);
    host.select(1'b0);
    check(4'(hold), 4'h0);
    host.write_reg(`RTCIRQ_ADDR_CTRL_F, 4'h5);
    rd(`RTCIRQ_ADDR_CTRL_F, 4'h0, 1'b0);
    check(cf, 4'hA);
    host.select(1'b1);
    rd(`RTCIRQ_ADDR_CTRL_F, 4'hA, 1'b1);
    check(4'(hold), 4'h0);
    results();
  end
endmodule : tb
